// ---- rtl/wfd_pkg.sv ----
package wfd_pkg;
  localparam int NUM_FILTERS = 4;
  localparam int TABLE_WORDS = 8;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_TABLE_PORT = 8'h04;
  localparam logic [7:0] ADDR_STATION_LO = 8'h08;
  localparam logic [7:0] ADDR_STATION_HI = 8'h0C;
  localparam logic [7:0] ADDR_POWER = 8'h10;
  // control / status bit positions
  localparam int BIT_MAGIC_EN = 1;
  localparam int BIT_PATTERN_EN = 2;
  localparam int BIT_MAGIC_RX = 4;
  localparam int BIT_PATTERN_RX = 5;
  localparam int BIT_NOTIFY_IRQ = 8;
  localparam int BIT_NOTIFY_PME = 9;
  // filter command bits
  localparam int CMD_ENABLE = 0;
  localparam int CMD_MULTICAST = 3;
  localparam int MASK_BITS = 31;
  localparam int MIN_OFFSET = 12;
  localparam int ADDR_BYTES = 6;
  localparam int SYNC_BYTES = 6;
  localparam int MAGIC_REPS = 16;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [47:0] BROADCAST = 48'hFFFF_FFFF_FFFF;
endpackage

// ---- rtl/wfd_tbl_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface wfd_tbl_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [31:0] wr_data;
  logic [2:0] rd_idx;
  logic [31:0] rd_data;
  modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ---- rtl/wfd_filter_table.sv ----
`timescale 1ns/1ps
`default_nettype none
module wfd_filter_table
  import wfd_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  wfd_tbl_if.mem tbl,
  output logic [TABLE_WORDS*32-1:0] words_out
);
  logic [31:0] mem_ff [TABLE_WORDS];
  logic [31:0] rd_ff;
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < TABLE_WORDS; i++)
        mem_ff[i] <= RESET_WORD;
    end
    else if (tbl.wr_en)
      mem_ff[tbl.wr_idx] <= tbl.wr_data;
  end
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rd_ff <= RESET_WORD;
    else
      rd_ff <= mem_ff[tbl.rd_idx];
  end
  assign tbl.rd_data = rd_ff;
  always_comb
  begin
    for (int i = 0; i < TABLE_WORDS; i++)
      words_out[i*32 +: 32] = mem_ff[i];
  end
endmodule
`default_nettype wire

// ---- rtl/wfd_wake_frame_detector.sv ----
// Overview of operation
// - mask bit j feeds byte offset+j
// - command bit 3 picks multicast or unicast
// - command bit 0 enables the filter
// - 8-bit offset, zero is first address byte
// - computed CRC equal to stored means wake
// - magic enable blocks normal reception
// - magic detect notifies via irq or pme
// - magic detect sets magic received status
// - clearing magic enable restores reception
// - magic check takes own or broadcast
// - multicast frames accepted for magic too
// - search six FF sync bytes after addresses
// - sixteen unbroken station address copies needed
// - broken run resumes sync search
// - sync must directly precede the copies
// - light sleep forces both detections on
// - pattern enable blocks reception, sets status
// - four independent programmable filters
`timescale 1ns/1ps
`default_nettype none
module wfd_wake_frame_detector
  import wfd_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [31:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic WB_WE_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic RX_SOF_IN,
  input wire logic RX_VALID_IN,
  input wire logic [7:0] RX_DATA_IN,
  input wire logic RX_EOF_IN,
  output logic RX_NORMAL_EN_OUT,
  output logic HOST_IRQ_OUT,
  output logic POWER_EVENT_OUT
);
  import wfd_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--)
    begin
      if (r[15] ^ d[b])
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction

  wfd_tbl_if tbl ();
  logic [TABLE_WORDS*32-1:0] tbl_words;
  wfd_filter_table u_table (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .tbl(tbl),
    .words_out(tbl_words)
  );

  logic magic_en_ff;
  logic pattern_en_ff;
  logic magic_rx_ff;
  logic pattern_rx_ff;
  logic notify_irq_ff;
  logic notify_pme_ff;
  logic sleep_ff;
  logic [2:0] tbl_ptr_ff;
  logic [47:0] station_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [2:0] nxt_tbl_ptr;
  logic magic_hit;
  logic pattern_hit;
  logic magic_active;
  logic pattern_active;
  logic [7:0] adr;
  logic req;
  logic wr_ok;

  assign adr = WB_ADR_IN[7:0];
  assign req = WB_CYC_IN && WB_STB_IN && !ack_ff;
  assign wr_ok = req && WB_WE_IN && (&WB_SEL_IN);
  // light sleep forces both detections on
  assign magic_active = magic_en_ff || sleep_ff;
  assign pattern_active = pattern_en_ff || sleep_ff;

  // table port: successive writes walk the eight words
  assign tbl.wr_en = wr_ok && adr == ADDR_TABLE_PORT;
  assign tbl.wr_idx = tbl_ptr_ff;
  assign tbl.wr_data = WB_DAT_IN;
  // read index runs one step ahead, so the memory register holds the current word
  assign nxt_tbl_ptr = (req && adr == ADDR_TABLE_PORT) ? tbl_ptr_ff + 3'h1
    : (wr_ok && adr == ADDR_CTRL_STATUS) ? 3'h0 : tbl_ptr_ff;
  assign tbl.rd_idx = nxt_tbl_ptr;

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      tbl_ptr_ff <= 3'h0;
    else
      tbl_ptr_ff <= nxt_tbl_ptr;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      magic_en_ff <= 1'b0;
      pattern_en_ff <= 1'b0;
      notify_irq_ff <= 1'b0;
      notify_pme_ff <= 1'b0;
      sleep_ff <= 1'b0;
      station_ff <= 48'h0;
    end
    else if (wr_ok)
    begin
      unique case (adr)
        ADDR_CTRL_STATUS:
        begin
          magic_en_ff <= WB_DAT_IN[BIT_MAGIC_EN];
          pattern_en_ff <= WB_DAT_IN[BIT_PATTERN_EN];
          notify_irq_ff <= WB_DAT_IN[BIT_NOTIFY_IRQ];
          notify_pme_ff <= WB_DAT_IN[BIT_NOTIFY_PME];
        end
        ADDR_STATION_LO: station_ff[31:0] <= WB_DAT_IN;
        ADDR_STATION_HI: station_ff[47:32] <= WB_DAT_IN[15:0];
        ADDR_POWER: sleep_ff <= WB_DAT_IN[0];
        default: ;
      endcase
    end
  end

  // status bits: write one clears, a hit in the same cycle wins
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      magic_rx_ff <= 1'b0;
      pattern_rx_ff <= 1'b0;
    end
    else
    begin
      if (magic_hit)
        magic_rx_ff <= 1'b1;
      else if (wr_ok && adr == ADDR_CTRL_STATUS && WB_DAT_IN[BIT_MAGIC_RX])
        magic_rx_ff <= 1'b0;
      if (pattern_hit)
        pattern_rx_ff <= 1'b1;
      else if (wr_ok && adr == ADDR_CTRL_STATUS && WB_DAT_IN[BIT_PATTERN_RX])
        pattern_rx_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req;
    end
  end
  assign WB_ACK_OUT = ack_ff;

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      rdat_ff <= 32'h0;
    else if (req && !WB_WE_IN)
    begin
      rdat_ff <= 32'h0;
      unique case (adr)
        ADDR_CTRL_STATUS:
        begin
          rdat_ff[BIT_MAGIC_EN] <= magic_en_ff;
          rdat_ff[BIT_PATTERN_EN] <= pattern_en_ff;
          rdat_ff[BIT_MAGIC_RX] <= magic_rx_ff;
          rdat_ff[BIT_PATTERN_RX] <= pattern_rx_ff;
          rdat_ff[BIT_NOTIFY_IRQ] <= notify_irq_ff;
          rdat_ff[BIT_NOTIFY_PME] <= notify_pme_ff;
        end
        ADDR_TABLE_PORT: rdat_ff <= tbl.rd_data;
        ADDR_STATION_LO: rdat_ff <= station_ff[31:0];
        ADDR_STATION_HI: rdat_ff <= {16'h0, station_ff[47:32]};
        ADDR_POWER: rdat_ff <= {31'h0, sleep_ff};
        default: rdat_ff <= 32'h0;
      endcase
    end
  end
  // every read source lands in one register, so the bus sees no mux
  assign WB_DAT_OUT = rdat_ff;

  // either detector blocks normal frame delivery
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      RX_NORMAL_EN_OUT <= 1'b1;
    else
      RX_NORMAL_EN_OUT <= !(magic_active || pattern_active);
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      HOST_IRQ_OUT <= 1'b0;
      POWER_EVENT_OUT <= 1'b0;
    end
    else
    begin
      HOST_IRQ_OUT <= notify_irq_ff && (magic_rx_ff || pattern_rx_ff);
      POWER_EVENT_OUT <= notify_pme_ff && (magic_rx_ff || pattern_rx_ff);
    end
  end

  // frame position and destination capture
  logic [10:0] pos_ff;
  logic [47:0] dest_ff;
  logic in_frame_ff;
  logic [7:0] dbyte;
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      pos_ff <= 11'h0;
      dest_ff <= 48'h0;
      in_frame_ff <= 1'b0;
    end
    else if (RX_VALID_IN)
    begin
      pos_ff <= RX_SOF_IN ? 11'h1 : pos_ff + 11'h1;
      in_frame_ff <= !RX_EOF_IN;
      if (RX_SOF_IN)
        dest_ff <= {RX_DATA_IN, 40'h0};
      else if (pos_ff < 11'(ADDR_BYTES))
        dest_ff[8*(5-pos_ff[2:0]) +: 8] <= RX_DATA_IN;
    end
  end
  logic [10:0] cur_pos;
  assign cur_pos = RX_SOF_IN ? 11'h0 : pos_ff;
  assign dbyte = RX_DATA_IN;

  // destination type, valid once the address field is in
  logic dest_mcast;
  logic dest_own;
  logic dest_bcast;
  assign dest_mcast = dest_ff[40];
  assign dest_own = dest_ff == station_ff;
  assign dest_bcast = dest_ff == BROADCAST;

  // magic detector
  typedef enum {MG_SYNC, MG_ADDR} wfd_magic_t;
  wfd_magic_t mg_state_ff;
  logic [2:0] mg_cnt_ff;
  logic [4:0] mg_rep_ff;
  logic mg_done_ff;
  logic [7:0] st_byte;
  logic body;
  assign body = RX_VALID_IN && cur_pos >= 11'(2*ADDR_BYTES);
  assign st_byte = station_ff[8*(5-mg_cnt_ff) +: 8];

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN || (RX_VALID_IN && RX_SOF_IN))
    begin
      mg_state_ff <= MG_SYNC;
      mg_cnt_ff <= 3'h0;
      mg_rep_ff <= 5'h0;
      mg_done_ff <= 1'b0;
    end
    else if (body && !mg_done_ff)
    begin
      unique case (mg_state_ff)
        MG_SYNC:
          if (dbyte == SYNC_BYTE)
          begin
            if (mg_cnt_ff == 3'(SYNC_BYTES - 1))
            begin
              mg_state_ff <= MG_ADDR;
              mg_cnt_ff <= 3'h0;
              mg_rep_ff <= 5'h0;
            end
            else
              mg_cnt_ff <= mg_cnt_ff + 3'h1;
          end
          else
            mg_cnt_ff <= 3'h0;
        MG_ADDR:
          if (dbyte == st_byte)
          begin
            if (mg_cnt_ff == 3'(ADDR_BYTES - 1))
            begin
              mg_cnt_ff <= 3'h0;
              mg_rep_ff <= mg_rep_ff + 5'h1;
              if (mg_rep_ff == 5'(MAGIC_REPS - 1))
                mg_done_ff <= 1'b1;
            end
            else
              mg_cnt_ff <= mg_cnt_ff + 3'h1;
          end
          else
          begin
            // broken run: rescan; an FF here may open a new sync
            mg_state_ff <= MG_SYNC;
            mg_cnt_ff <= (dbyte == SYNC_BYTE) ? 3'h1 : 3'h0;
          end
      endcase
    end
  end
  // decided at end of frame once the destination is known
  assign magic_hit = magic_active && RX_VALID_IN && RX_EOF_IN && mg_done_ff
    && (dest_own || dest_bcast || dest_mcast);

  // pattern filters
  logic [15:0] crc_ff [NUM_FILTERS];
  logic [NUM_FILTERS-1:0] f_hit;
  always_comb
  begin
    for (int f = 0; f < NUM_FILTERS; f++)
    begin
      f_hit[f] = tbl_words[4*32 + 8*f + CMD_ENABLE]
        && (tbl_words[4*32 + 8*f + CMD_MULTICAST] == dest_mcast)
        && (crc_ff[f] == tbl_words[(6 + f/2)*32 + 16*(f%2) +: 16]);
    end
  end
  always_ff @(posedge CLK_IN)
  begin
    for (int f = 0; f < NUM_FILTERS; f++)
    begin
      logic [30:0] msk;
      logic [7:0] off;
      logic [10:0] rel;
      msk = tbl_words[f*32 +: MASK_BITS];
      off = tbl_words[5*32 + 8*f +: 8];
      rel = cur_pos - {3'h0, off};
      if (RESET_IN || (RX_VALID_IN && RX_SOF_IN))
        crc_ff[f] <= CRC_INIT;
      else if (RX_VALID_IN && cur_pos >= {3'h0, off} && rel < 11'(MASK_BITS)
        && msk[rel[4:0]])
        crc_ff[f] <= crc_step(crc_ff[f], dbyte);
    end
  end
  // compared after the last byte has been folded in
  logic eof_d_ff;
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      eof_d_ff <= 1'b0;
    else
      eof_d_ff <= RX_VALID_IN && RX_EOF_IN;
  end
  assign pattern_hit = pattern_active && eof_d_ff && (|f_hit);
endmodule
`default_nettype wire

// ---- tb/wfd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module wfd_checker (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic WB_WE_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  input wire logic RX_VALID_IN,
  input wire logic RX_EOF_IN,
  input wire logic RX_NORMAL_EN_OUT,
  input wire logic HOST_IRQ_OUT,
  input wire logic POWER_EVENT_OUT
);
  logic [2:0] cause_ff;
  logic req;
  assign req = WB_CYC_IN && WB_STB_IN;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // irq and normal enable may move, and pme may rise, only shortly after a frame end or a register write
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      cause_ff <= 3'h0;
    else if ((RX_VALID_IN && RX_EOF_IN) || (WB_ACK_OUT && WB_WE_IN))
      cause_ff <= 3'h4;
    else if (cause_ff != 3'h0)
      cause_ff <= cause_ff - 3'h1;
  end
  a_ack_one_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property ((req && !WB_ACK_OUT) |=> WB_ACK_OUT)
    else $error("request not acked next cycle");
  a_ack_needs_req: assert property (!req |=> !WB_ACK_OUT)
    else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) RESET_IN |=>
    (!HOST_IRQ_OUT && !POWER_EVENT_OUT && RX_NORMAL_EN_OUT && !WB_ACK_OUT))
    else $error("outputs not at reset values");
  a_irq_rise_cause: assert property ($rose(HOST_IRQ_OUT) |-> cause_ff != 3'h0)
    else $error("irq rose without frame end or write");
  a_pme_rise_cause: assert property ($rose(POWER_EVENT_OUT) |-> cause_ff != 3'h0)
    else $error("pme rose without frame end or write");
  a_irq_fall_cause: assert property ($fell(HOST_IRQ_OUT) |-> cause_ff != 3'h0)
    else $error("irq fell without write");
  a_norm_en_cause: assert property ($changed(RX_NORMAL_EN_OUT) |-> cause_ff != 3'h0)
    else $error("normal enable moved without write");
  cover property ($rose(HOST_IRQ_OUT));
  cover property ($rose(POWER_EVENT_OUT));
  cover property ($fell(RX_NORMAL_EN_OUT));
endmodule
bind wfd_wake_frame_detector wfd_checker i_chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
  .WB_WE_IN(WB_WE_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_ACK_OUT(WB_ACK_OUT), .RX_VALID_IN(RX_VALID_IN), .RX_EOF_IN(RX_EOF_IN),
  .RX_NORMAL_EN_OUT(RX_NORMAL_EN_OUT), .HOST_IRQ_OUT(HOST_IRQ_OUT),
  .POWER_EVENT_OUT(POWER_EVENT_OUT));
`default_nettype wire

// ---- tb/wfd_rx_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module wfd_rx_src (
  input wire logic clk_in,
  output logic sof_out,
  output logic valid_out,
  output logic eof_out,
  output logic [7:0] data_out
);
  initial
  begin
    sof_out = 1'b0;
    valid_out = 1'b0;
    eof_out = 1'b0;
    data_out = 8'h00;
  end
  // idle bus inverts its byte on each idle cycle, so every second idle cycle shows the last byte again
  task automatic idle();
    @(posedge clk_in);
    sof_out <= 1'b0;
    valid_out <= 1'b0;
    eof_out <= 1'b0;
    data_out <= ~data_out;
  endtask
  task automatic send(input logic [7:0] f [$], input int gap);
    for (int i = 0; i < f.size(); i++)
    begin
      @(posedge clk_in);
      sof_out <= (i == 0);
      valid_out <= 1'b1;
      eof_out <= (i == f.size() - 1);
      data_out <= f[i];
      repeat (gap) idle();
    end
    idle();
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wfd_pkg::*;
  localparam logic [47:0] MC = 48'h0100_5E00_0001;
  logic clk, rst, we, cyc, stb, ack, sof, vld, eof, norm, irq, power_event_output;
  logic [31:0] adr, wdat, rdat, q, ctl;
  logic [7:0] rxd;
  logic [47:0] sta;
  logic [7:0] fr [$];
  int n_fail, checks;
  wfd_wake_frame_detector i_dut (.CLK_IN(clk), .RESET_IN(rst), .WB_ADR_IN(adr),
    .WB_DAT_IN(wdat), .WB_SEL_IN(4'hF), .WB_WE_IN(we), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .RX_SOF_IN(sof), .RX_VALID_IN(vld),
    .RX_DATA_IN(rxd), .RX_EOF_IN(eof), .RX_NORMAL_EN_OUT(norm), .HOST_IRQ_OUT(irq),
    .POWER_EVENT_OUT(power_event_output));
  wfd_rx_src i_src (.clk_in(clk), .sof_out(sof), .valid_out(vld), .eof_out(eof),
    .data_out(rxd));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {24'h0, a};
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40)
      chk(32'h1, 32'h0);
  endtask
  task automatic put(input logic [47:0] v);
    for (int i = 5; i >= 0; i--)
      fr.push_back(v[8*i +: 8]);
  endtask
  task automatic hdr(input logic [47:0] d);
    fr = {};
    put(d);
    put(48'h5A5A_5A5A_5A5A);
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] b);
    logic [15:0] c;
    c = CRC_INIT;
    for (int k = 15; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? CRC_POLY : 16'h0);
    return c;
  endfunction
  // k: 0 good, 1 short run, 2 broken then good, 3 gap after sync, 4 no sync
  task automatic mt(input logic [47:0] d, input int k, input logic e);
    hdr(d);
    if (k == 2)
    begin
      put({6{SYNC_BYTE}});
      repeat (15) put(sta);
      fr.push_back(8'h00);
    end
    if (k != 4)
      put({6{SYNC_BYTE}});
    if (k == 3)
      fr.push_back(8'h00);
    repeat (k == 1 ? 15 : 16) put(sta);
    fr.push_back(8'h77);
    i_src.send(fr, k);
    repeat (5) @(posedge clk);
    wb(ADDR_CTRL_STATUS, 1'b0, 32'h0);
    chk(q[BIT_MAGIC_RX], e);
    chk(irq, e);
    wb(ADDR_CTRL_STATUS, 1'b1, ctl | 32'h30);
  endtask
  task automatic pt(input logic [3:0] c, input logic [47:0] d, input logic e);
    logic [31:0] tw [8];
    hdr(d);
    for (int i = 0; i < 8; i++)
      fr.push_back(8'h30 + 8'(i));
    tw = '{default: 32'h0};
    tw[3] = 32'h0000_0005;
    tw[4] = {4'h0, c, 24'h0};
    tw[5] = {8'(MIN_OFFSET), 24'h0};
    tw[7] = {crc16({fr[12], fr[14]}), 16'h0};
    wb(ADDR_CTRL_STATUS, 1'b1, 32'h0);
    for (int i = 0; i < TABLE_WORDS; i++)
      wb(ADDR_TABLE_PORT, 1'b1, tw[i]);
    ctl = (32'h1 << BIT_PATTERN_EN) | (32'h1 << BIT_NOTIFY_PME);
    wb(ADDR_CTRL_STATUS, 1'b1, ctl);
    for (int i = 0; i < TABLE_WORDS; i++)
    begin
      wb(ADDR_TABLE_PORT, 1'b0, 32'h0);
      chk(q, tw[i]);
    end
    chk(norm, 1'b0);
    i_src.send(fr, 0);
    repeat (5) @(posedge clk);
    wb(ADDR_CTRL_STATUS, 1'b0, 32'h0);
    chk(q[BIT_PATTERN_RX], e);
    chk(power_event_output, e);
    wb(ADDR_CTRL_STATUS, 1'b1, ctl | 32'h30);
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    {we, cyc, stb} = 3'h0;
    adr = 32'h0;
    wdat = 32'h0;
    ctl = 32'h0;
    sta = 48'h0211_2233_4455;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(8'h14, 1'b0, 32'h0);
    chk(q, 32'h0);
    chk({norm, irq, power_event_output}, 32'h4);
    wb(ADDR_STATION_LO, 1'b1, sta[31:0]);
    wb(ADDR_STATION_HI, 1'b1, {16'h0, sta[47:32]});
    ctl = (32'h1 << BIT_MAGIC_EN) | (32'h1 << BIT_NOTIFY_IRQ);
    wb(ADDR_CTRL_STATUS, 1'b1, ctl);
    repeat (2) @(posedge clk);
    chk(norm, 1'b0);
    mt(sta, 0, 1'b1);
    mt(sta, 1, 1'b0);
    mt(sta, 2, 1'b1);
    mt(sta, 3, 1'b0);
    mt(BROADCAST, 4, 1'b0);
    mt(BROADCAST, 0, 1'b1);
    mt(48'h0A00_0000_0001, 0, 1'b0);
    mt(MC, 0, 1'b1);
    ctl = 32'h1 << BIT_NOTIFY_IRQ;
    wb(ADDR_CTRL_STATUS, 1'b1, ctl);
    repeat (2) @(posedge clk);
    chk(norm, 1'b1);
    wb(ADDR_POWER, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    chk(norm, 1'b0);
    mt(sta, 0, 1'b1);
    wb(ADDR_POWER, 1'b1, 32'h0);
    pt(4'h1, sta, 1'b1);
    pt(4'h0, sta, 1'b0);
    pt(4'h1, MC, 1'b0);
    pt(4'h9, MC, 1'b1);
    wb(ADDR_CTRL_STATUS, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    chk(norm, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
